// ==== hdl/pll_ctrl_defs.svh ====
// offsets, field positions, reset values and timing counts of the pll control block
`ifndef PLL_CTRL_DEFS_SVH
`define PLL_CTRL_DEFS_SVH

// serial programming word
`define WORD_BITS 24
`define SEL_REF 2'h0
`define SEL_N 2'h1
`define SEL_FUNC 2'h2
`define SEL_INIT 2'h3

// function and initialization latch fields
`define FN_COUNTER_RESET 2
`define FN_PD_REQUEST 3
`define FN_FS_ENABLE 9
`define FN_FS_MODE 10
`define FN_TSEL_LO 11
`define FN_TSEL_HI 14
`define FN_CUR1_LO 15
`define FN_CUR1_HI 17
`define FN_CUR2_LO 18
`define FN_CUR2_HI 20
`define FN_PD_SYNC 21
`define FN_PRESC_LO 22
`define FN_PRESC_HI 23

// n counter latch fields
`define N_A_LO 2
`define N_A_HI 7
`define N_B_LO 8
`define N_B_HI 20
`define N_FAST_REQ 21

// reference counter latch field
`define R_DIV_LO 2
`define R_DIV_HI 15

// latch reset values
`define LATCH_RESET 24'h000000

// register byte offsets
`define REG_REF 5'h00
`define REG_N 5'h04
`define REG_FUNC 5'h08
`define REG_STATUS 5'h0C
`define REG_TUNIT 5'h10

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// timeout step: time in ns, cycle count derived from the clock period
`define CLK_PERIOD_NS 10
`define TIMEOUT_UNIT_NS 1000
`define TIMEOUT_UNIT_CYCLES (`TIMEOUT_UNIT_NS / `CLK_PERIOD_NS)

`endif

// ==== hdl/pll_ctrl_pkg.sv ====
// types shared by the pll control block
package pll_ctrl_pkg;

  // power-down sequencing
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_ARMED,
    PWR_DOWN
  } pwr_state_e;

  typedef logic [23:0] prog_word_t;

endpackage

// ==== hdl/pll_fast_settle_latch_control.sv ====
// pll digital control: latches, fast-settle timer, internal reset, power-down, axi regs
//
// Contract
// RULE1 - programming words are 24 bits, shifted msb first, one bit per serial clock rise
// RULE2 - latch-load rise copies the word to the latch named by its two low bits
// RULE3 - function bit 9 enables fast settle; bit 10 picks manual or timer exit
// RULE4 - function bit 2 set holds reference and a/b counters in reset
// RULE5 - in timer mode, writing the fast request bit selects the secondary current
// RULE6 - in timer mode, the device clears the fast request itself after the timeout
// RULE7 - timeout length comes from function bits 14 down to 11
// RULE8 - request set uses secondary current; on timeout revert to primary and clear
// RULE9 - the timeout counter runs only when function bit 10 is one
// RULE10 - primary current is the low current field, secondary the high field
// RULE11 - host keeps the prescaler output at or below 200 mhz
// RULE12 - initialization load stores function fields and also fires an internal reset
// RULE13 - internal reset loads reference, n and timeout counters and tristates the pump
// RULE14 - internal reset also enters power-down when chip enable and pd request allow it
// RULE15 - first n load after an initialization refires the pulse; later ones do not
// RULE16 - host start-up: init latch with counter reset clear, then reference, then n
// RULE17 - chip enable low powers down at once; raising it resumes counting
// RULE18 - latch contents survive chip enable toggling
// RULE19 - host start-up: function with reset set, reference, n, function with reset clear
// RULE20 - counter reset holds counters and tristates the pump but never powers down
// RULE21 - an n load setting the request in timer mode restarts the timeout from zero
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pll_ctrl_defs.svh"

module pll_fast_settle_latch_control
  import pll_ctrl_pkg::*;
#(
  parameter int ADDR_W = 5,
  parameter logic [15:0] TIMEOUT_UNIT_RESET = 16'(`TIMEOUT_UNIT_CYCLES)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // serial programming pins
  input wire logic sclk,
  input wire logic sdata,
  input wire logic latchLoadStrobe,
  // chip enable pin and charge pump event from the phase detector
  input wire logic chipEnable,
  input wire logic cpEvent,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // divider settings
  output logic [13:0] refDivide,
  output logic [5:0] aCount,
  output logic [12:0] bCount,
  output logic [1:0] prescalerSelect,
  // charge pump and counter control
  output logic [2:0] cpCurrent,
  output logic cpTristate,
  output logic countersHeld,
  output logic powerDown,
  output logic fastSettleActive,
  output logic internalResetPulse
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic rstMeta, rstN;
  logic ceMeta, ceSync;
  logic cpMeta, cpSync, cpLast;

  // reset asserts at once but releases only after two clean edges
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {rstMeta, rstN} <= 2'h0;
    end else begin
      {rstMeta, rstN} <= {1'b1, rstMeta};
    end
  end

  // chip enable and pump event come from outside the clock domain
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      {ceMeta, ceSync} <= 2'h0;
      {cpMeta, cpSync, cpLast} <= 3'h0;
    end else begin
      {ceMeta, ceSync} <= {chipEnable, ceMeta};
      {cpMeta, cpSync, cpLast} <= {cpEvent, cpMeta, cpSync};
    end
  end

  wire cpEventRise = cpSync && !cpLast;

  ////////////////////////////////////////////////////////////////////////////
  // serial word capture

  prog_word_t word;
  logic wordValid;

  serial_word_capture #(.WIDTH(`WORD_BITS)) u_capture (
    .ref_clk(ref_clk),
    .rstN(rstN),
    .sclk(sclk),
    .sdata(sdata),
    .latchLoadStrobe(latchLoadStrobe),
    .word(word),
    .wordValid(wordValid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // latch decode

  prog_word_t refLatch_reg, nLatch_reg, funcLatch_reg;
  logic timeout;

  wire [1:0] latchSel = word[1:0];
  wire loadRef = wordValid && (latchSel == `SEL_REF); // RULE2
  wire loadN = wordValid && (latchSel == `SEL_N);
  wire loadInit = wordValid && (latchSel == `SEL_INIT);
  // both select codes with the high bit set write the function fields
  wire loadFunc = wordValid && latchSel[1]; // RULE12

  wire fsEnable = funcLatch_reg[`FN_FS_ENABLE];
  wire fsTimerMode = funcLatch_reg[`FN_FS_MODE];
  wire fastRequest = nLatch_reg[`N_FAST_REQ];
  wire [3:0] timeoutSelect = funcLatch_reg[`FN_TSEL_HI:`FN_TSEL_LO]; // RULE7
  wire [2:0] currentSettingOne = funcLatch_reg[`FN_CUR1_HI:`FN_CUR1_LO];
  wire [2:0] currentSettingTwo = funcLatch_reg[`FN_CUR2_HI:`FN_CUR2_LO];
  wire counterResetBit = funcLatch_reg[`FN_COUNTER_RESET];
  wire powerDownRequest = funcLatch_reg[`FN_PD_REQUEST];
  wire powerDownSyncSelect = funcLatch_reg[`FN_PD_SYNC];

  // latches clear only on reset; chip enable never touches them
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      refLatch_reg <= `LATCH_RESET;
      funcLatch_reg <= `LATCH_RESET;
    end else begin
      if (loadRef) begin
        refLatch_reg <= word;
      end
      if (loadFunc) begin
        funcLatch_reg <= word; // RULE18
      end
    end
  end

  // a fresh n load wins over a timeout landing in the same cycle
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      nLatch_reg <= `LATCH_RESET;
    end else if (loadN) begin
      nLatch_reg <= word;
    end else if (timeout) begin
      nLatch_reg[`N_FAST_REQ] <= 1'b0; // RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal reset pulse

  logic pendingN_reg;

  wire pulseNext = loadInit || (loadN && pendingN_reg); // RULE15

  // armed by every initialization load, spent by the next n load
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pendingN_reg <= 1'b0;
      internalResetPulse <= 1'b0;
    end else begin
      internalResetPulse <= pulseNext; // RULE12
      if (loadInit) begin
        pendingN_reg <= 1'b1;
      end else if (loadN) begin
        pendingN_reg <= 1'b0; // RULE15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fast-settle timeout: (timeoutSelect + 1) steps of timeoutUnit cycles

  logic [15:0] timeoutUnit_reg;
  logic [15:0] tickCnt_reg;
  logic [3:0] stepCnt_reg;

  wire timerArmed = fastRequest && fsEnable && fsTimerMode; // RULE9
  wire timerRestart = loadN && word[`N_FAST_REQ]; // RULE21
  // a zero unit would never wrap, so it acts as one cycle
  wire [15:0] unitLast = (timeoutUnit_reg == 16'h0000) ? 16'h0000 : timeoutUnit_reg - 16'h0001;
  wire tickWrap = (tickCnt_reg == unitLast);
  assign timeout = timerArmed && !timerRestart && !internalResetPulse && tickWrap
                   && (stepCnt_reg == timeoutSelect); // RULE6

  // the counter idles at zero whenever it is not armed
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      tickCnt_reg <= 16'h0000;
      stepCnt_reg <= 4'h0;
    end else if (!timerArmed || timerRestart || internalResetPulse || timeout) begin
      tickCnt_reg <= 16'h0000; // RULE13
      stepCnt_reg <= 4'h0;
    end else if (tickWrap) begin
      tickCnt_reg <= 16'h0000;
      stepCnt_reg <= stepCnt_reg + 4'h1;
    end else begin
      tickCnt_reg <= tickCnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down sequencing

  pwr_state_e pwr_reg, pwr_next;

  // synchronous mode waits for a pump event; the internal pulse stands in for one
  always_comb begin
    pwr_next = pwr_reg;
    if (!ceSync) begin
      pwr_next = PWR_DOWN; // RULE17
    end else if (!powerDownRequest) begin
      pwr_next = PWR_RUN;
    end else if (internalResetPulse) begin
      pwr_next = PWR_DOWN; // RULE14
    end else if (!powerDownSyncSelect) begin
      pwr_next = PWR_DOWN;
    end else begin
      unique case (pwr_reg)
        PWR_RUN: pwr_next = PWR_ARMED;
        PWR_ARMED: pwr_next = cpEventRise ? PWR_DOWN : PWR_ARMED;
        PWR_DOWN: pwr_next = PWR_DOWN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pwr_reg <= PWR_DOWN;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // charge pump and counter outputs

  wire fastActive = fastRequest && fsEnable; // RULE3
  wire pwrDownNext = (pwr_next == PWR_DOWN);
  // counter reset holds and tristates only; it has no path into power-down
  wire holdNext = pulseNext || counterResetBit || pwrDownNext; // RULE20

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      cpCurrent <= 3'h0;
      fastSettleActive <= 1'b0;
      countersHeld <= 1'b1;
      cpTristate <= 1'b1;
      powerDown <= 1'b1;
    end else begin
      cpCurrent <= fastActive ? currentSettingTwo : currentSettingOne; // RULE8 RULE10 RULE5
      fastSettleActive <= fastActive;
      countersHeld <= holdNext; // RULE4 RULE13
      cpTristate <= holdNext;
      powerDown <= pwrDownNext;
    end
  end

  assign refDivide = refLatch_reg[`R_DIV_HI:`R_DIV_LO];
  assign aCount = nLatch_reg[`N_A_HI:`N_A_LO];
  assign bCount = nLatch_reg[`N_B_HI:`N_B_LO];
  assign prescalerSelect = funcLatch_reg[`FN_PRESC_HI:`FN_PRESC_LO];

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  function automatic logic regHit(input logic [ADDR_W-1:0] addr);
    regHit = (addr == `REG_REF) || (addr == `REG_N) || (addr == `REG_FUNC)
             || (addr == `REG_STATUS) || (addr == `REG_TUNIT);
  endfunction

  logic awHeld_reg, wHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;

  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire wrFire = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  wire unitWrite = wrFire && (awAddr_reg == `REG_TUNIT);

  // address and data are caught separately in either order
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
    end else begin
      if (awTake) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld_reg <= 1'b0;
      end
      if (wTake) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  // only the timeout unit is writable; latches change over the serial pins, and the n latch fast request bit also clears on timeout
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      timeoutUnit_reg <= TIMEOUT_UNIT_RESET;
    end else if (unitWrite) begin
      if (wStrb_reg[0]) timeoutUnit_reg[7:0] <= wData_reg[7:0];
      if (wStrb_reg[1]) timeoutUnit_reg[15:8] <= wData_reg[15:8];
    end
  end

  // write response
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= regHit(awAddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read mux
  wire [31:0] statusWord = {21'h000000, cpCurrent, 1'b0, ceSync, powerDown, cpTristate,
                            countersHeld, pendingN_reg, timerArmed, fastSettleActive};
  wire [31:0] readMux =
    (s_axi_araddr == `REG_REF) ? {8'h00, refLatch_reg} :
    (s_axi_araddr == `REG_N) ? {8'h00, nLatch_reg} :
    (s_axi_araddr == `REG_FUNC) ? {8'h00, funcLatch_reg} :
    (s_axi_araddr == `REG_STATUS) ? statusWord :
    (s_axi_araddr == `REG_TUNIT) ? {16'h0000, timeoutUnit_reg} : 32'h00000000;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readMux;
      s_axi_rresp <= regHit(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // pll_fast_settle_latch_control

// ==== hdl/serial_word_capture.sv ====
// three-wire serial input: synchronisers, shift register and latch-load capture
`timescale 1ns/1ps
`include "pll_ctrl_defs.svh"

module serial_word_capture
  import pll_ctrl_pkg::*;
#(
  parameter int WIDTH = `WORD_BITS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstN,
  // serial pins
  input wire logic sclk,
  input wire logic sdata,
  input wire logic latchLoadStrobe,
  // captured word
  output logic [WIDTH-1:0] word,
  output logic wordValid
);

  logic sclkMeta, sclkSync, sclkLast;
  logic sdataMeta, sdataSync;
  logic leMeta, leSync, leLast;
  logic [WIDTH-1:0] shift_reg;

  // data is synchronised with the same depth as the clock so they stay aligned
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      {sclkMeta, sclkSync, sclkLast} <= 3'h0;
      {sdataMeta, sdataSync} <= 2'h0;
      {leMeta, leSync, leLast} <= 3'h0;
    end else begin
      {sclkMeta, sclkSync, sclkLast} <= {sclk, sclkMeta, sclkSync};
      {sdataMeta, sdataSync} <= {sdata, sdataMeta};
      {leMeta, leSync, leLast} <= {latchLoadStrobe, leMeta, leSync};
    end
  end

  wire sclkRise = sclkSync && !sclkLast;
  wire leRise = leSync && !leLast;

  // msb first: each new bit enters at the bottom
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      shift_reg <= '0;
    end else if (sclkRise) begin
      shift_reg <= {shift_reg[WIDTH-2:0], sdataSync}; // RULE1
    end
  end

  // word presented for one cycle on the strobe's rising edge
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      word <= '0;
      wordValid <= 1'b0;
    end else begin
      wordValid <= leRise; // RULE2
      if (leRise) begin
        word <= shift_reg;
      end
    end
  end

endmodule // serial_word_capture

// ==== verif/host_serial_model.sv ====
// host side of the serial link
`timescale 1ns/1ps
module host_serial_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstN,
  // word request
  input wire logic go,
  input wire logic [23:0] word,
  output logic busy,
  // serial pins
  output logic sclk,
  output logic sdata,
  output logic latchLoadStrobe
);
  logic [7:0] cnt;
  logic [23:0] sh;
  // four clocks low, four high per bit
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      sh <= 24'h000000;
      sclk <= 1'b0;
      sdata <= 1'b0;
      latchLoadStrobe <= 1'b0;
    end else if (!busy) begin
      sdata <= ~sdata; // idle data toggles
      busy <= go;
      cnt <= 8'h00;
      sh <= word;
    end else begin
      cnt <= cnt + 8'h01;
      sclk <= (cnt < 8'hC0) && cnt[2];
      if (cnt < 8'hC0) sdata <= sh[5'h17 - cnt[7:3]];
      latchLoadStrobe <= (cnt > 8'hC0) && (cnt < 8'hC5);
      busy <= (cnt != 8'hCB);
    end
  end
endmodule // host_serial_model

// ==== verif/pll_ctrl_sva.sv ====
// checks on the pll control block ports
`timescale 1ns/1ps
module pll_ctrl_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // pins
  input wire logic latchLoadStrobe,
  input wire logic chipEnable,
  input wire logic cpEvent,
  // read channel
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // pump control
  input wire logic [2:0] cpCurrent,
  input wire logic cpTristate,
  input wire logic countersHeld,
  input wire logic powerDown,
  input wire logic fastSettleActive,
  input wire logic internalResetPulse
);
  logic [7:0] leHist;
  logic [7:0] evHist;
  logic [1:0] fsaHist;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // cause history
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      leHist <= 8'h00;
      evHist <= 8'h00;
      fsaHist <= 2'h0;
    end else begin
      leHist <= {leHist[6:0], latchLoadStrobe};
      evHist <= {evHist[6:0], latchLoadStrobe | cpEvent | ~chipEnable};
      fsaHist <= {fsaHist[0], fastSettleActive};
    end
  end
  ////////////////////////////////////////
  // relations
  property p_pulse_one; internalResetPulse |=> !internalResetPulse; endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");
  property p_pulse_cause; internalResetPulse |-> |leHist; endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without load");
  property p_fast_cause; $rose(fastSettleActive) |-> |leHist; endproperty
  a_fast_cause: assert property (p_fast_cause) else $error("fast mode without load");
  property p_cur_cause;
    $changed(cpCurrent) |-> |leHist || (fsaHist[0] != fastSettleActive) || (fsaHist[1] != fsaHist[0]);
  endproperty
  a_cur_cause: assert property (p_cur_cause) else $error("current moved alone");
  property p_held_pair; countersHeld == cpTristate; endproperty
  a_held_pair: assert property (p_held_pair) else $error("held and tristate differ");
  property p_ce_down; !chipEnable [*5] |-> powerDown; endproperty
  a_ce_down: assert property (p_ce_down) else $error("enable low not down");
  property p_pd_cause; $rose(powerDown) |-> |evHist; endproperty
  a_pd_cause: assert property (p_pd_cause) else $error("down without cause");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
  // scenarios
  c_pulse: cover property (internalResetPulse);
  c_fast_end: cover property ($fell(fastSettleActive) && !(|leHist));
  c_pd: cover property ($rose(powerDown) && chipEnable);
endmodule // pll_ctrl_sva

bind pll_fast_settle_latch_control pll_ctrl_sva u_sva (
  .ref_clk, .reset_n, .latchLoadStrobe, .chipEnable, .cpEvent, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .cpCurrent, .cpTristate, .countersHeld, .powerDown, .fastSettleActive,
  .internalResetPulse
);

// ==== verif/tb_top.sv ====
// self-checking pll control bench
`timescale 1ns/1ps
`include "pll_ctrl_defs.svh"
module tb_top
  import pll_ctrl_pkg::*;
;
  localparam int UNIT = 20;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic chipEnable = 1'b1;
  logic cpEvent = 1'b0;
  logic go = 1'b0;
  prog_word_t word = 24'h000000;
  logic busy, sclk, sdata, latchLoadStrobe;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, prescalerSelect;
  logic [13:0] refDivide;
  logic [5:0] aCount;
  logic [12:0] bCount;
  logic [2:0] cpCurrent, c1, c2;
  logic cpTristate, countersHeld, powerDown, fastSettleActive, internalResetPulse;
  int n_errors = 0, total_checks = 0, pulses = 0, cyc = 0;
  logic [15:0] rnd = 16'hB508;

  pll_fast_settle_latch_control dut (.ref_clk, .reset_n, .sclk, .sdata, .latchLoadStrobe,
    .chipEnable, .cpEvent, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .refDivide, .aCount, .bCount, .prescalerSelect, .cpCurrent, .cpTristate,
    .countersHeld, .powerDown, .fastSettleActive, .internalResetPulse);
  host_serial_model host (.ref_clk, .rstN(reset_n), .go, .word, .busy, .sclk, .sdata,
    .latchLoadStrobe);

  ////////////////////////////////////////
  // clock, ceiling, tally
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (internalResetPulse === 1'b1) pulses <= pulses + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  ////////////////////////////////////////
  // expectation helpers
  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic prog_word_t fw(logic [1:0] sel, logic pd2, logic pd1, logic crst,
      logic en, logic md, logic [3:0] ts);
    return {2'h1, pd2, c2, c1, ts, md, en, 5'h00, pd1, crst, sel};
  endfunction
  function automatic prog_word_t nw(logic f, logic [12:0] b, logic [5:0] a);
    return {2'h0, f, b, a, 2'h1};
  endfunction
  function automatic prog_word_t nr(logic f);
    return nw(f, rnd[12:0], rnd[5:0]);
  endfunction
  // expiry is seen 5 cycles early
  function automatic logic near(int n, int e);
    return (n >= e - 7) && (n <= e - 1);
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////
  // drive after rising edges, sample at falling edges
  task automatic send(input prog_word_t w);
    @(posedge ref_clk);
    word <= w;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    do @(negedge ref_clk); while (busy === 1'b1);
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa = 1'b1, pw = 1'b1;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge ref_clk);
      pa = pa & ~s_axi_awready;
      pw = pw & ~s_axi_wready;
      @(posedge ref_clk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do @(negedge ref_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge ref_clk); while (s_axi_arready !== 1'b1);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask

  ////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] ts;
    int n;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rnd = lfsr(rnd);
    c1 = rnd[2:0];
    c2 = rnd[2:0] ^ 3'h5;
    // register map
    axr(`REG_FUNC, d, r);
    chk(d, 32'h0);
    axw(`REG_REF, 32'hFFFFFF, r);
    chk(32'(r), 32'(`RESP_OKAY));
    axr(`REG_REF, d, r);
    chk(d, 32'h0);
    axr(5'h14, d, r);
    chk(32'(r), 32'(`RESP_SLVERR));
    axw(5'h1C, 32'h1, r);
    chk(32'(r), 32'(`RESP_SLVERR));
    axw(`REG_TUNIT, UNIT, r);
    axr(`REG_TUNIT, d, r);
    chk(d, UNIT);
    // init start-up
    send(fw(2'h3, 0, 0, 0, 0, 0, 4'h0));
    chk(pulses, 1);
    rnd = lfsr(rnd);
    send({8'h00, rnd[13:0], 2'h0});
    chk(32'(refDivide), 32'(rnd[13:0]));
    send(nw(0, rnd[15:3], rnd[5:0]));
    chk(pulses, 2);
    chk(32'(bCount), 32'(rnd[15:3]));
    chk(32'(aCount), 32'(rnd[5:0]));
    send(nw(0, rnd[12:0], rnd[9:4]));
    chk(pulses, 2);
    chk(32'(cpCurrent), 32'(c1));
    chk(32'(prescalerSelect), 32'h1);
    // timer exit, one restart
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      ts = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : rnd[3:0];
      send(fw(2'h2, 0, 0, 0, 1, 1, ts));
      send(nr(1));
      chk(32'(fastSettleActive), 32'h1);
      chk(32'(cpCurrent), 32'(c2));
      if (i == 1) send(nr(1));
      n = 0;
      do begin
        @(negedge ref_clk);
        n++;
      end while (fastSettleActive === 1'b1 && n < 2000);
      chk(32'(near(n, (ts + 1) * UNIT)), 32'h1);
      axr(`REG_N, d, r);
      chk(32'(d[21]), 32'h0);
      chk(32'(cpCurrent), 32'(c1));
    end
    // manual exit, disabled
    send(fw(2'h2, 0, 0, 0, 1, 0, 4'h0));
    send(nr(1));
    repeat (100) @(negedge ref_clk);
    chk(32'(fastSettleActive), 32'h1);
    send(nr(0));
    chk(32'(cpCurrent), 32'(c1));
    send(fw(2'h2, 0, 0, 0, 0, 1, 4'h0));
    send(nr(1));
    chk(32'(fastSettleActive), 32'h0);
    // counter-reset start-up
    send(fw(2'h2, 0, 0, 1, 0, 0, 4'h0));
    chk(32'(countersHeld), 32'h1);
    chk(32'(powerDown), 32'h0);
    send({8'h00, rnd[13:0], 2'h0});
    send(nr(0));
    send(fw(2'h2, 0, 0, 0, 0, 0, 4'h0));
    chk(32'(countersHeld), 32'h0);
    // chip-enable start-up, toggle
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      chipEnable <= 1'b0;
      repeat (6) @(negedge ref_clk);
      chk(32'(powerDown), 32'h1);
      if (k == 0) send({8'h00, ~rnd[13:0], 2'h0});
      @(posedge ref_clk);
      chipEnable <= 1'b1;
      repeat (6) @(negedge ref_clk);
      chk(32'(powerDown), 32'h0);
      chk(32'(refDivide), 32'(14'(~rnd[13:0])));
    end
    // gated power-down
    send(fw(2'h2, 1, 1, 0, 0, 0, 4'h0));
    chk(32'(powerDown), 32'h0);
    @(posedge ref_clk);
    cpEvent <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cpEvent <= 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(32'(powerDown), 32'h1);
    send(fw(2'h2, 0, 0, 0, 0, 0, 4'h0));
    chk(32'(powerDown), 32'h0);
    send(fw(2'h3, 1, 1, 0, 0, 0, 4'h0));
    chk(32'(powerDown), 32'h1);
    results();
  end
endmodule // tb_top
